// ---- hw/gee_port.v ----
// eight-pin port with direction, level and edge events
`timescale 1ns/1ps
// -----------------------------------------------------------------
// -----------------------------------------------------------------
`include "gee_regs.vh"
module gee_port #(
    parameter NPIN = 8
) (
    input  wire            i_clk,
    input  wire            i_srst,
    input  wire [7:0]      i_addr,
    input  wire [7:0]      i_wdata,
    input  wire            i_wr,
    input  wire            i_rd,
    output reg  [7:0]      o_rdata,
    input  wire [NPIN-1:0] i_pin,
    output reg  [NPIN-1:0] o_pin,
    output reg  [NPIN-1:0] o_pin_oe,
    output reg             o_mgmt_interrupt,
    output reg             o_reload_timer_b,
    output reg             o_lid_status,
    output reg             o_wake
);
    reg  [NPIN-1:0] dir_r;
    reg  [NPIN-1:0] out_r;
    reg  [7:0]      ctrl_r;
    reg  [7:0]      stat_r;
    reg  [7:0]      stat_nxt;
    reg  [7:0]      ien_r;
    reg  [2:0]      tmr_r;
    reg  [2:0]      wclr_r;
    wire [NPIN-1:0] lvl;
    wire [NPIN-1:0] chg;
    wire [2:0]      whit;
    wire [2:0]      wake_ev;
    wire            p7_ev;
    wire            lid_ev;
    wire [7:0]      clr_mask;
    genvar g;

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    // sync before edges
    gee_sync #(.WIDTH(NPIN)) u_sync (
        .i_clk    (i_clk),
        .i_srst   (i_srst),
        .i_async  (i_pin),
        .o_stable (lvl),
        .o_change (chg)
    );

    // -----------------------------------------------------------------
    // clockless wake latches on pins 0 to 2
    // -----------------------------------------------------------------
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_wake
            gee_wake u_wake (
                .i_pin  (i_pin[g]),
                .i_fall (ctrl_r[`GEE_CTL_FALL_LO + g]),
                .i_en   (ctrl_r[g] & ~dir_r[g]),
                .i_clr  (wclr_r[g]),
                .o_hit  (whit[g])
            );
            // clearing the status bit re-arms the latch for the next edge
            always @(posedge i_clk) begin
                if (i_srst) begin
                    wclr_r[g] <= 1'b1;
                end else begin
                    wclr_r[g] <= clr_mask[`GEE_ST_PIN0 + g];
                end
            end
        end
    endgenerate

    // three-stage crossing of latch outputs, event on agreed rise
    reg [2:0] ws1_r;
    reg [2:0] ws2_r;
    reg [2:0] ws3_r;
    reg [2:0] wseen_r;
    always @(posedge i_clk) begin
        if (i_srst) begin
            ws1_r   <= 3'h0;
            ws2_r   <= 3'h0;
            ws3_r   <= 3'h0;
            wseen_r <= 3'h0;
        end else begin
            ws1_r   <= whit;
            ws2_r   <= ws1_r;
            ws3_r   <= ws2_r;
            wseen_r <= ws2_r & ws3_r;
        end
    end
    assign wake_ev = ws2_r & ws3_r & ~wseen_r;

    // -----------------------------------------------------------------
    // pin 6 lid and pin 7 events
    // -----------------------------------------------------------------
    // both edges while lid enabled
    assign lid_ev = ctrl_r[`GEE_CTL_LID_EN] & ~dir_r[`GEE_PIN_LID] &
                    chg[`GEE_PIN_LID];
    // edge chosen by control bit 7
    assign p7_ev = ~dir_r[`GEE_PIN_RELOAD] & chg[`GEE_PIN_RELOAD] &
                   (lvl[`GEE_PIN_RELOAD] ==
                    ctrl_r[`GEE_CTL_RELOAD_FALL]);
    // clear only on write to the clear register
    assign clr_mask = (i_wr && i_addr == `GEE_OFS_CLR) ? i_wdata :
                      `GEE_RST_BYTE;

    // status next value: set beats clear
    always @* begin
        stat_nxt = stat_r & ~clr_mask;
        // lid sets bits 3 and 0
        if (lid_ev) begin
            stat_nxt[`GEE_ST_LID] = 1'b1;
            stat_nxt[`GEE_ST_TOP] = 1'b1;
        end
        if (wake_ev != 3'h0) begin
            stat_nxt[`GEE_ST_PIN0 +: 3] = stat_nxt[`GEE_ST_PIN0 +: 3] |
                wake_ev;
            stat_nxt[`GEE_ST_TOP] = 1'b1;
        end
        // pin 7 interrupt has own enable
        if (p7_ev && tmr_r[`GEE_TMR_P7_INT]) begin
            stat_nxt[`GEE_ST_PIN7] = 1'b1;
            stat_nxt[`GEE_ST_TOP]  = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // registers and events
    // -----------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_srst) begin
            dir_r            <= `GEE_RST_BYTE;
            out_r            <= `GEE_RST_BYTE;
            ctrl_r           <= `GEE_RST_BYTE;
            stat_r           <= `GEE_RST_BYTE;
            ien_r            <= `GEE_RST_BYTE;
            tmr_r            <= 3'h0;
            o_lid_status     <= 1'b0;
            o_reload_timer_b <= 1'b0;
            o_mgmt_interrupt <= 1'b0;
            o_wake           <= 1'b0;
        end else begin
            if (i_wr) begin
                case (i_addr)
                    `GEE_OFS_DIR:   dir_r  <= i_wdata;
                    `GEE_OFS_LEVEL: out_r  <= i_wdata;
                    `GEE_OFS_CTRL:  ctrl_r <= i_wdata;
                    `GEE_OFS_IEN:   ien_r  <= i_wdata;
                    `GEE_OFS_TMR:   tmr_r  <= i_wdata[2:0];
                    default:        ien_r  <= ien_r;
                endcase
            end
            stat_r <= stat_nxt;
            if (lid_ev) begin
                o_lid_status <= ~o_lid_status;
            end
            // reload needs timer and reload enable
            o_reload_timer_b <= p7_ev & tmr_r[`GEE_TMR_EN] &
                                tmr_r[`GEE_TMR_RLD_EN];
            o_mgmt_interrupt <= |(stat_nxt & ien_r);
            // synchronised copy, the raw latch is not on this clock
            o_wake           <= |(ws2_r & ws3_r);
        end
    end

    // pin drive, held in flops
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_pin    <= `GEE_RST_BYTE;
            o_pin_oe <= `GEE_RST_BYTE;
        end else begin
            o_pin    <= out_r & dir_r;
            o_pin_oe <= dir_r;
        end
    end

    // read port, data one cycle after the strobe
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= `GEE_RST_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                `GEE_OFS_DIR:   o_rdata <= dir_r;
                `GEE_OFS_LEVEL: o_rdata <= (lvl & ~dir_r) | (out_r & dir_r);
                `GEE_OFS_CTRL:  o_rdata <= ctrl_r;
                `GEE_OFS_STAT:  o_rdata <= stat_r;
                `GEE_OFS_IEN:   o_rdata <= ien_r;
                `GEE_OFS_TMR:   o_rdata <= {5'h00, tmr_r};
                default:        o_rdata <= `GEE_RST_BYTE;
            endcase
        end else begin
            o_rdata <= `GEE_RST_BYTE;
        end
    end
endmodule

// ---- hw/gee_regs.vh ----
// register offsets, field positions and reset values of the pin port
`ifndef GEE_REGS_VH
`define GEE_REGS_VH
`define GEE_OFS_DIR      8'h90
`define GEE_OFS_LEVEL    8'h91
`define GEE_OFS_CTRL     8'h92
`define GEE_OFS_STAT     8'ha0
`define GEE_OFS_CLR      8'ha1
`define GEE_OFS_IEN      8'ha2
`define GEE_OFS_TMR      8'ha3
`define GEE_RST_BYTE     8'h00
`define GEE_CTL_RELOAD_FALL 7
`define GEE_CTL_LID_EN   6
`define GEE_CTL_FALL_LO  3
`define GEE_CTL_FALL_HI  5
`define GEE_CTL_WEN_HI   2
`define GEE_PIN_RELOAD   7
`define GEE_PIN_LID      6
`define GEE_ST_TOP       0
`define GEE_ST_LID       3
`define GEE_ST_PIN0      5
`define GEE_ST_PIN7      1
`define GEE_TMR_EN       0
`define GEE_TMR_RLD_EN   1
`define GEE_TMR_P7_INT   2
`endif

// ---- hw/gee_sync.v ----
// three-stage synchroniser for a bank of pin inputs
`timescale 1ns/1ps
module gee_sync #(
    parameter WIDTH = 8
) (
    input  wire             i_clk,
    input  wire             i_srst,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_stable,
    output wire [WIDTH-1:0] o_change
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    reg [WIDTH-1:0] lvl_r;
    genvar g;
    // -----------------------------------------------------------------
    // per-bit stages
    // -----------------------------------------------------------------
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            // stage one feeds stage two only; a level counts once 2 and 3 agree
            always @(posedge i_clk) begin
                if (i_srst) begin
                    s1_r[g]  <= 1'b0;
                    s2_r[g]  <= 1'b0;
                    s3_r[g]  <= 1'b0;
                    lvl_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= i_async[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        lvl_r[g] <= s3_r[g];
                    end
                end
            end
            assign o_change[g] = (s2_r[g] == s3_r[g]) &&
                                 (s3_r[g] != lvl_r[g]);
        end
    endgenerate
    assign o_stable = lvl_r;
endmodule

// ---- hw/gee_wake.v ----
// clockless edge latch for one wake pin, held until the clocked side clears
`timescale 1ns/1ps
module gee_wake (
    input  wire i_pin,
    input  wire i_fall,
    input  wire i_en,
    input  wire i_clr,
    output wire o_hit
);
    wire edge_pin;
    reg  hit_r;
    // the pin itself clocks the latch, so it works while clocks are stopped
    assign edge_pin = i_pin ^ i_fall;
    always @(posedge edge_pin or posedge i_clr) begin
        if (i_clr) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= i_en;
        end
    end
    assign o_hit = hit_r;
endmodule

// ---- tb/gee_pins_model.sv ----
// far-side switch bank sharing the port's pins
`timescale 1ns/1ps
module gee_pins_model (
    input  wire [7:0] i_sw,
    input  wire [7:0] i_drv,
    input  wire [7:0] i_oe,
    output wire [7:0] o_level
);
    // a driven pin shows the port, others follow the switch
    assign o_level = (i_drv & i_oe) | (i_sw & ~i_oe);
endmodule

// ---- tb/gee_port_properties.sv ----
// assertion checker for the eight-pin port
`timescale 1ns/1ps
module gee_port_chk #(
    parameter NPIN = 8
) (
    input wire            i_clk, i_srst, i_wr, i_rd,
    input wire [7:0]      i_addr, i_wdata, o_rdata,
    input wire [NPIN-1:0] i_pin, o_pin, o_pin_oe,
    input wire            o_mgmt_interrupt, o_reload_timer_b,
    input wire            o_lid_status, o_wake
);
    reg [7:0] ctrl_r;
    reg [7:0] ien_r;
    reg [3:0] c6_r;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // shadows of control and enable writes
    always @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_r <= 8'h00;
            ien_r <= 8'h00;
        end else if (i_wr && i_addr == 8'h92) begin
            ctrl_r <= i_wdata;
        end else if (i_wr && i_addr == 8'ha2) begin
            ien_r <= i_wdata;
        end
    end
    // age of last pin 6 move; saturates so a stale toggle shows
    always @(posedge i_clk) begin
        if (i_srst || $changed(i_pin[6]))
            c6_r <= 4'h0;
        else if (c6_r != 4'hf)
            c6_r <= c6_r + 4'h1;
    end
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray");
    property p_oe_dir;
        i_wr && i_addr == 8'h90 |-> ##2 o_pin_oe == $past(i_wdata, 2);
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("dir");
    property p_out_wr;
        i_wr && i_addr == 8'h91 |-> ##2
            ((o_pin ^ $past(i_wdata, 2)) & o_pin_oe) == 0;
    endproperty
    a_out_wr: assert property (p_out_wr) else $error("drive");
    property p_rld_pulse; o_reload_timer_b |=> !o_reload_timer_b; endproperty
    a_rld_pulse: assert property (p_rld_pulse) else $error("long");
    property p_rld_edge; o_reload_timer_b |-> i_pin[7] != ctrl_r[7]; endproperty
    a_rld_edge: assert property (p_rld_edge) else $error("edge");
    property p_lid_en; $changed(o_lid_status) |-> ctrl_r[6]; endproperty
    a_lid_en: assert property (p_lid_en) else $error("lid off");
    property p_lid_win; $changed(o_lid_status) |-> c6_r <= 4'h6; endproperty
    a_lid_win: assert property (p_lid_win) else $error("lid late");
    property p_int_en; o_mgmt_interrupt |-> $past(ien_r) != 8'h00; endproperty
    a_int_en: assert property (p_int_en) else $error("masked");
    property p_wake_en; $rose(o_wake) |-> ctrl_r[2:0] != 3'h0; endproperty
    a_wake_en: assert property (p_wake_en) else $error("wake");
    c_rld: cover property (o_reload_timer_b);
    c_lid: cover property ($changed(o_lid_status));
    c_int: cover property ($rose(o_mgmt_interrupt));
endmodule
bind gee_port gee_port_chk #(.NPIN(NPIN)) u_chk (.i_clk(i_clk),
    .i_srst(i_srst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_pin(i_pin), .o_pin(o_pin),
    .o_pin_oe(o_pin_oe), .o_mgmt_interrupt(o_mgmt_interrupt),
    .o_reload_timer_b(o_reload_timer_b), .o_lid_status(o_lid_status),
    .o_wake(o_wake));

// ---- tb/gee_port_tb.sv ----
// self-checking bench for the eight-pin port
`timescale 1ns/1ps
module gee_port_tb;
    reg        i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    reg        rd_d = 1'b0;
    reg  [7:0] i_addr = 8'h00, i_wdata = 8'h00, sw = 8'h00, d, v;
    reg  [7:0] q[$];
    wire [7:0] o_rdata, i_pin, o_pin, o_pin_oe;
    wire       o_mgmt_interrupt, o_reload_timer_b, o_lid_status, o_wake;
    integer    mismatches = 0, checks_done = 0, pulses = 0, k, r;
    always #20 i_clk = ~i_clk;
    gee_pins_model far (.i_sw(sw), .i_drv(o_pin), .i_oe(o_pin_oe),
        .o_level(i_pin));
    gee_port dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
        .o_mgmt_interrupt(o_mgmt_interrupt),
        .o_reload_timer_b(o_reload_timer_b),
        .o_lid_status(o_lid_status), .o_wake(o_wake));
    task chk(input [7:0] s, input [7:0] e);
        begin
            checks_done = checks_done + 1;
            if (s !== e) begin
                mismatches = mismatches + 1;
                $display("ERROR t=%0t seen %h exp %h", $time, s, e);
            end
        end
    endtask
    // one strobe cycle; a read notes its expected data
    task bus(input w, input [7:0] a, input [7:0] x);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_wdata <= x;
            i_wr <= w;
            i_rd <= ~w;
            if (!w) q.push_back(x);
            @(posedge i_clk);
            i_wr <= 1'b0;
            i_rd <= 1'b0;
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge i_clk) begin
        rd_d <= i_rd;
        if (rd_d)
            chk(o_rdata, q.pop_front());
        if (o_reload_timer_b === 1'b1)
            pulses = pulses + 1;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches = mismatches + 1;
        complete_run;
    end
    initial begin
        r = $urandom(77);
        repeat (12) @(posedge i_clk);
        i_srst <= 1'b0;
        for (k = 0; k < 4; k = k + 1)
            bus(1'b0, 8'h8f + k[7:0], 8'h00);
        $display("test reset done");
        for (k = 0; k < 3; k = k + 1) begin
            r = $urandom;
            d = r[7:0];
            v = r[15:8];
            sw <= r[23:16];
            bus(1'b1, 8'h90, d);
            bus(1'b1, 8'h91, v);
            idle(6);
            chk(o_pin_oe, d);
            // only output pins drive their written level
            chk(o_pin, v & d);
            bus(1'b0, 8'h90, d);
            bus(1'b0, 8'h91, (v & d) | (sw & ~d));
        end
        $display("test levels done");
        // all inputs before any event use
        sw <= 8'h00;
        bus(1'b1, 8'h90, 8'h00);
        bus(1'b1, 8'h92, 8'h40);
        bus(1'b1, 8'ha1, 8'hff);
        bus(1'b1, 8'ha2, 8'hff);
        for (k = 0; k < 2; k = k + 1) begin
            sw[6] <= ~sw[6];
            idle(8);
            chk({6'h00, o_mgmt_interrupt, o_lid_status}, {6'h00, {2{~k[0]}}});
            bus(1'b0, 8'ha0, 8'h09);
            bus(1'b1, 8'ha1, 8'hff);
            bus(1'b1, 8'ha2, 8'h00);
        end
        $display("test lid done");
        // both edge selects, with timer on and with only pin 7 interrupt
        for (k = 0; k < 4; k = k + 1) begin
            bus(1'b1, 8'h92, {k[0], 7'h00});
            bus(1'b1, 8'ha3, k[1] ? 8'h04 : 8'h03);
            pulses = 0;
            sw[7] <= 1'b1;
            idle(8);
            sw[7] <= 1'b0;
            idle(8);
            chk(pulses[7:0], {7'h00, ~k[1]});
            bus(1'b0, 8'ha0, k[1] ? 8'h03 : 8'h00);
            bus(1'b1, 8'ha1, 8'hff);
        end
        $display("test reload done");
        // pin 0 rising, pin 1 falling, pin 2 disabled
        // edge selects first, so a select change cannot look like an edge
        bus(1'b1, 8'h92, 8'h10);
        bus(1'b1, 8'h92, 8'h13);
        sw[2:0] <= 3'h7;
        idle(8);
        bus(1'b0, 8'ha0, 8'h21);
        sw[2:0] <= 3'h0;
        idle(8);
        bus(1'b0, 8'ha0, 8'h61);
        chk({7'h00, o_wake}, 8'h01);
        idle(3);
        $display("test wake done");
        complete_run;
    end
endmodule
